// [rtl/ast_core.sv]
// Serial transceiver core and its transmit FIFO.
// Assumes the CPU access strobes are synchronous to mclk; pins are not.
`timescale 1ns/1ps

module ast_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("ast_fifo depth must be a power of two");
    end

    // Handshake terms
    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage has no reset; only pointers and fill level need one
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

module ast_core #(
    parameter int TX_DEPTH = 32
)
(
    input wire logic mclk,
    input wire logic resetn,
    input ast_pkg::ast_req_t cpu_req,
    output logic [7:0] reg_rdata,
    input wire logic rx_clk_pin,
    input wire logic rx_data_pin,
    input wire logic tx_clk_pin,
    output logic tx_data_pin,
    output logic tx_irq
);
    import ast_pkg::*;

    typedef enum logic {TX_IDLE, TX_SHIFT} ast_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ast_rx_t;

    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic rx_tick;
    logic tx_fall;
    logic rxd;
    logic rx_en, rx_full, pe, ovr, fe, ctl;
    logic [7:0] rx_data;
    logic it_sel, shift_empty;
    logic [7:0] ien, mode_a, mode_b;
    logic [15:0] baud;
    logic wr0, wr1, wr_data, rd_data;
    logic [3:0] nbits;
    logic [5:0] div_last;
    logic brk;
    logic fifo_ready, fifo_valid, tx_pop;
    logic [7:0] fifo_dout;
    logic [5:0] tx_div;
    logic tx_bit_en;
    ast_tx_t tx_st;
    logic [FRAME_W-1:0] tx_frame, tx_new;
    logic [3:0] tx_left, tx_pos;
    logic tx_par, tx_done;
    ast_rx_t rx_st;
    logic [5:0] rx_cnt;
    logic [3:0] rx_nbit, rx_need;
    logic [RXW-1:0] rx_sh, rx_word;
    logic rx_sample, rx_done;
    logic [7:0] rx_byte, rx_val;
    logic rx_calc, rx_pbit, rx_wbit, rx_stop, rx_take;

    // Pin synchronisers
    // Clock pins are sampled like data; they must run well below mclk/2.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_s1 <= 3'h7;
            pin_s2 <= 3'h7;
            pin_s3 <= 3'h7;
        end
        else
        begin
            pin_s1 <= {rx_clk_pin, rx_data_pin, tx_clk_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign rx_tick = pin_s2[2] && !pin_s3[2];
    assign tx_fall = !pin_s2[0] && pin_s3[0];
    assign rxd = pin_s2[1];

    assign wr0 = cpu_req.wr && !cpu_req.bank;
    assign wr1 = cpu_req.wr && cpu_req.bank;
    assign wr_data = wr0 && cpu_req.addr == DATA_ADDR;
    assign rd_data = cpu_req.rd && !cpu_req.bank && cpu_req.addr == DATA_ADDR;

    // Mode fields
    // Length shared by both directions
    assign nbits = LEN_BASE + {2'b00, mode_a[MA_LEN +: 2]};
    assign brk = mode_b[MB_BRK];
    always_comb
    begin
        case (mode_a[MA_DIV +: 2])
            2'h0: div_last = DIV1_LAST;
            2'h1: div_last = DIV16_LAST;
            2'h2: div_last = DIV32_LAST;
            default: div_last = DIV64_LAST;
        endcase
    end

    // Configuration registers, baud pair high then low
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ien <= ZERO8;
            mode_a <= ZERO8;
            mode_b <= ZERO8;
            baud <= '0;
            it_sel <= 1'b0;
        end
        else
        begin
            if (wr0 && cpu_req.addr == IRQEN_ADDR)
                ien <= cpu_req.wdata;
            if (wr0 && cpu_req.addr == TXIT_ADDR)
                it_sel <= cpu_req.wdata[TXI_SEL];
            if (wr1 && cpu_req.addr == MODEA_ADDR)
                mode_a <= cpu_req.wdata;
            if (wr1 && cpu_req.addr == MODEB_ADDR)
                mode_b <= cpu_req.wdata;
            if (wr1 && cpu_req.addr == BAUDH_ADDR)
                baud[15:8] <= cpu_req.wdata;
            if (wr1 && cpu_req.addr == BAUDL_ADDR)
                baud[7:0] <= cpu_req.wdata;
        end
    end

    // Writes to the data address queue for transmit
    // A write while the queue is full is dropped; poll the empty flag.
    ast_fifo #(.WIDTH(DATA_W), .DEPTH(TX_DEPTH)) u_txq (
        .clk(mclk),
        .resetn(resetn),
        .in_valid(wr_data),
        .in_ready(fifo_ready),
        .in_data(cpu_req.wdata),
        .out_valid(fifo_valid),
        .out_ready(tx_pop),
        .out_data(fifo_dout)
    );

    // Move into the shifter when it is free
    assign tx_pop = fifo_valid && tx_st == TX_IDLE && !brk;

    // Frame build: start, data, parity, wake, stops
    always_comb
    begin
        tx_new = '1;
        tx_new[0] = 1'b0;
        tx_par = mode_a[MA_ODD];
        tx_pos = nbits + 4'h1;
        for (int i = 0; i < DATA_W; i++)
        begin
            // Bits above the length are ignored
            if (i < int'(nbits))
            begin
                tx_new[i+1] = fifo_dout[i];
                tx_par = tx_par ^ fifo_dout[i];
            end
        end
        if (mode_a[MA_PAR])
        begin
            tx_new[tx_pos] = tx_par;
            tx_pos = tx_pos + 4'h1;
        end
        if (mode_a[MA_WAKE])
        begin
            tx_new[tx_pos] = mode_b[MB_WBIT];
            tx_pos = tx_pos + 4'h1;
        end
        tx_pos = tx_pos + (mode_a[MA_STOP2] ? 4'h2 : 4'h1);
    end

    // Bit enable from transmit clock falls
    assign tx_bit_en = tx_fall && tx_div == div_last;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            tx_div <= '0;
        else if (tx_fall)
            tx_div <= tx_bit_en ? 6'h00 : tx_div + 6'h01;
    end

    // Transmit shifter; the last stop bit gets a full bit time
    assign tx_done = tx_bit_en && tx_st == TX_SHIFT && tx_left == '0;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_st <= TX_IDLE;
            tx_frame <= '1;
            tx_left <= '0;
            tx_data_pin <= 1'b1;
        end
        else
        begin
            if (tx_pop)
            begin
                tx_frame <= tx_new;
                tx_left <= tx_pos;
                tx_st <= TX_SHIFT;
            end
            else if (tx_done)
                tx_st <= TX_IDLE;
            else if (tx_bit_en && tx_st == TX_SHIFT)
            begin
                tx_frame <= {1'b1, tx_frame[FRAME_W-1:1]};
                tx_left <= tx_left - 4'h1;
            end
            // Pin only moves on a falling-edge bit enable
            if (tx_bit_en)
            begin
                if (brk)
                    tx_data_pin <= 1'b0;
                else if (tx_st == TX_SHIFT && tx_left != '0)
                    tx_data_pin <= tx_frame[0];
                else
                    tx_data_pin <= 1'b1;
            end
        end
    end

    // Shifter-empty flag; a new write wins over the set
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            shift_empty <= 1'b1;
        else if (wr_data)
            shift_empty <= 1'b0;
        else if (tx_done && !fifo_valid && !brk)
            shift_empty <= 1'b1;
    end

    // Transmit interrupt pulse, event picked by select bit
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            tx_irq <= 1'b0;
        else
            tx_irq <= ien[IEN_TX] && (it_sel ?
                (tx_done && !fifo_valid && !brk) : tx_pop);
    end

    assign rx_sample = rx_tick && rx_st == RX_BITS && rx_cnt == div_last;
    assign rx_need = nbits + {3'b000, mode_a[MA_PAR]}
        + {3'b000, mode_a[MA_WAKE]} + 4'h1;
    assign rx_done = rx_sample && rx_nbit == rx_need - 4'h1;
    assign rx_word = {rxd, rx_sh[RXW-1:1]} >> (4'(RXW) - rx_need);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_st <= RX_IDLE;
            rx_cnt <= '0;
            rx_nbit <= '0;
            rx_sh <= '1;
        end
        else if (!rx_en)
            rx_st <= RX_IDLE;
        else if (rx_tick)
        begin
            case (rx_st)
                RX_IDLE:
                begin
                    rx_nbit <= '0;
                    rx_cnt <= 6'h01;
                    if (!rxd)
                        rx_st <= div_last == DIV1_LAST ? RX_BITS : RX_START;
                    if (!rxd && div_last == DIV1_LAST)
                        rx_cnt <= '0;
                end
                RX_START:
                begin
                    // Low beyond half a bit is a start
                    if (rxd)
                        rx_st <= RX_IDLE;
                    else if (rx_cnt == (div_last >> 1) + 6'h01)
                    begin
                        rx_st <= RX_BITS;
                        rx_cnt <= '0;
                    end
                    else
                        rx_cnt <= rx_cnt + 6'h01;
                end
                RX_BITS:
                begin
                    if (rx_sample)
                    begin
                        rx_sh <= {rxd, rx_sh[RXW-1:1]};
                        rx_nbit <= rx_nbit + 4'h1;
                        rx_cnt <= '0;
                        if (rx_done)
                            rx_st <= RX_IDLE;
                    end
                    else
                        rx_cnt <= rx_cnt + 6'h01;
                end
                default: rx_st <= RX_IDLE;
            endcase
        end
    end

    // Pad with ones, keep parity bit in the byte
    always_comb
    begin
        rx_byte = 8'hff;
        rx_val = ZERO8;
        rx_calc = mode_a[MA_ODD];
        for (int i = 0; i < DATA_W; i++)
        begin
            if (i < int'(nbits))
            begin
                rx_byte[i] = rx_word[i];
                rx_val[i] = rx_word[i];
                rx_calc = rx_calc ^ rx_word[i];
            end
            else if (i == int'(nbits) && mode_a[MA_PAR])
                rx_byte[i] = rx_word[i];
        end
        rx_pbit = rx_word[nbits];
        rx_wbit = rx_word[nbits + {3'b000, mode_a[MA_PAR]}];
        rx_stop = rx_word[rx_need - 4'h1];
    end
    // Wake-up mode drops characters whose wake bit is low
    assign rx_take = rx_done && (!mode_a[MA_WAKE] || rx_wbit);

    // Receive status: hardware set wins over software clear
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_en <= RXCTL_RST[RXC_EN];
            pe <= 1'b0;
            ovr <= 1'b0;
            fe <= 1'b0;
            ctl <= 1'b0;
            rx_full <= 1'b0;
            rx_data <= ZERO8;
        end
        else
        begin
            if (wr0 && cpu_req.addr == RXCTL_ADDR)
            begin
                // Enable bit; writing zero clears flags
                rx_en <= cpu_req.wdata[RXC_EN];
                pe <= cpu_req.wdata[RXC_PE] & pe;
                ovr <= cpu_req.wdata[RXC_OVR] & ovr;
                fe <= cpu_req.wdata[RXC_FE] & fe;
            end
            if (rd_data)
                rx_full <= 1'b0;
            if (rx_take)
            begin
                rx_data <= rx_byte;
                rx_full <= 1'b1;
                ctl <= rx_val < CTL_LIMIT || rx_val == CTL_DEL;
                if (mode_a[MA_PAR] && rx_pbit != rx_calc)
                    pe <= 1'b1;
                if (!rx_stop)
                    fe <= 1'b1;
                if (rx_full && !rd_data)
                    ovr <= 1'b1;
            end
        end
    end

    // Registered read data; unmapped reads give zero
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= ZERO8;
        else if (cpu_req.rd)
        begin
            case ({cpu_req.bank, cpu_req.addr})
                {1'b0, RXCTL_ADDR}: reg_rdata <=
                    {2'b00, ctl, fe, ovr, pe, rx_full, rx_en};
                {1'b0, IRQEN_ADDR}: reg_rdata <= ien;
                {1'b0, TXIT_ADDR}: reg_rdata <=
                    {5'h00, !fifo_valid, shift_empty, it_sel};
                {1'b0, DATA_ADDR}: reg_rdata <= rx_data;
                {1'b1, BAUDH_ADDR}: reg_rdata <= baud[15:8];
                {1'b1, BAUDL_ADDR}: reg_rdata <= baud[7:0];
                {1'b1, MODEA_ADDR}: reg_rdata <= mode_a;
                {1'b1, MODEB_ADDR}: reg_rdata <= mode_b;
                default: reg_rdata <= ZERO8;
            endcase
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_TXD_ON_FALL: assert property (
        !$stable(tx_data_pin) |-> $past(tx_bit_en))
        else $error("serial output moved without a falling edge");
    AST_BREAK_LOW: assert property (
        brk && tx_bit_en |=> !tx_data_pin)
        else $error("break did not drive the line low");
    AST_IDLE_HIGH: assert property (
        tx_st == TX_IDLE && !brk && tx_bit_en |=> tx_data_pin)
        else $error("idle line not high");
    AST_EMPTY_CLEAR: assert property (
        wr_data |=> !shift_empty)
        else $error("shifter-empty flag not cleared by write");
    AST_EMPTY_NOT_BREAK: assert property (
        $rose(shift_empty) |-> !$past(brk) && $past(tx_done))
        else $error("shifter-empty set without a finished frame");
    AST_IRQ_HOLDING: assert property (
        tx_pop && !it_sel && ien[IEN_TX] |=> tx_irq)
        else $error("holding-empty interrupt missing");
    AST_IRQ_NOT_DISABLED: assert property (
        !ien[IEN_TX] |=> !tx_irq)
        else $error("interrupt raised while disabled");
    AST_RX_DISABLED: assert property (
        !rx_en |=> rx_st == RX_IDLE)
        else $error("receiver active while disabled");
    AST_OVERRUN: assert property (
        rx_take && rx_full && !rd_data |=> ovr && rx_full)
        else $error("overrun not flagged");
    AST_FE_STICKY: assert property (
        fe && !(wr0 && cpu_req.addr == RXCTL_ADDR) |=> fe)
        else $error("framing error lost without clear");

    AST_COV_TX_FRAME: cover property (tx_pop ##[1:1000] tx_done);
    AST_COV_RX_CHAR: cover property (rx_take && !fe && !pe);
    AST_COV_OVERRUN: cover property ($rose(ovr));
    AST_COV_BREAK: cover property (brk && tx_bit_en);
endmodule

// [rtl/ast_pkg.sv]
// Constants and carrier types for the asynchronous serial transceiver.
// Assumes a CPU register file with two banks and byte-wide accesses.
package ast_pkg;
    // Bank 0 addresses
    localparam logic [7:0] RXCTL_ADDR = 8'hec;
    localparam logic [7:0] IRQEN_ADDR = 8'hed;
    localparam logic [7:0] TXIT_ADDR = 8'hee;
    localparam logic [7:0] DATA_ADDR = 8'hef;
    // Bank 1 addresses
    localparam logic [7:0] BAUDH_ADDR = 8'hf8;
    localparam logic [7:0] BAUDL_ADDR = 8'hf9;
    localparam logic [7:0] MODEA_ADDR = 8'hfa;
    localparam logic [7:0] MODEB_ADDR = 8'hfb;
    // Receive control bit positions
    localparam int RXC_EN = 0;
    localparam int RXC_FULL = 1;
    localparam int RXC_PE = 2;
    localparam int RXC_OVR = 3;
    localparam int RXC_FE = 4;
    localparam int RXC_CTL = 5;
    // Transmit interrupt timing bits and enable bit
    localparam int TXI_SEL = 0;
    localparam int TXI_SEMPTY = 1;
    localparam int TXI_HEMPTY = 2;
    localparam int IEN_TX = 2;
    // Mode A fields and mode B bits
    localparam int MA_LEN = 0;
    localparam int MA_PAR = 2;
    localparam int MA_ODD = 3;
    localparam int MA_STOP2 = 4;
    localparam int MA_WAKE = 5;
    localparam int MA_DIV = 6;
    localparam int MB_BRK = 0;
    localparam int MB_WBIT = 1;
    // Character geometry and rate divider last counts
    localparam int DATA_W = 8;
    localparam int FRAME_W = 13;
    localparam int RXW = 11;
    localparam logic [3:0] LEN_BASE = 4'h5;
    localparam logic [5:0] DIV1_LAST = 6'h00;
    localparam logic [5:0] DIV16_LAST = 6'h0f;
    localparam logic [5:0] DIV32_LAST = 6'h1f;
    localparam logic [5:0] DIV64_LAST = 6'h3f;
    localparam logic [7:0] CTL_LIMIT = 8'h20;
    localparam logic [7:0] CTL_DEL = 8'h7f;
    localparam logic [7:0] RXCTL_RST = 8'h00;
    localparam logic [7:0] ZERO8 = 8'h00;
    // CPU register access carrier
    typedef struct packed {
        logic bank;
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } ast_req_t;
endpackage

// [testbench/ast_remote.sv]
// Far-end serial device: drives the receive pins, clocks and reads the
// transmit pin. Assumes the caller passes the rate divider of each frame.
`timescale 1ns/1ps
module ast_remote
(
    output logic rx_clk,
    output logic rx_data,
    output logic tx_clk,
    input wire logic tx_data
);
    localparam int HALF = 100;

    // Clocks stand still between frames; line marks high when idle
    initial
    begin
        rx_clk = 1'b0;
        rx_data = 1'b1;
        tx_clk = 1'b1;
    end

    task automatic send(input logic [12:0] bits, input int n, input int div);
        for (int i = 0; i < n; i++)
        begin
            rx_data = bits[i];
            repeat (div)
            begin
                #HALF rx_clk = 1'b1;
                #HALF rx_clk = 1'b0;
            end
        end
        rx_data = 1'b1;
    endtask

    // One transmit clock period, line sampled just before the rise
    task automatic tick(output logic b);
        #HALF tx_clk = 1'b0;
        #HALF b = tx_data;
        tx_clk = 1'b1;
    endtask

    // Hunt for the start bit under a bound, then collect the frame
    task automatic get(input int n, input int div, output logic [12:0] bits);
        logic b;
        int k;
        bits = '1;
        b = 1'b1;
        k = 0;
        while (b && k < 40 * div)
        begin
            tick(b);
            k++;
        end
        bits[0] = b;
        // Each bit changes div falls after the last; sample just after
        for (int i = 1; i < n; i++)
        begin
            repeat (div) tick(b);
            bits[i] = b;
        end
        // Rest of the stop bit and one more enable empty the shifter
        repeat (div) tick(b);
        tick(b);
    endtask
endmodule

// [testbench/ast_core_tb.sv]
// Self-checking bench for the serial transceiver core.
// Assumes the far-end model in ast_remote; the divider is set per frame.
`timescale 1ns/1ps
module ast_core_tb;
    import ast_pkg::*;
    logic mclk, resetn, tx_data_pin, tx_irq, rx_clk, rx_data, tx_clk, b;
    ast_req_t cpu_req;
    logic [7:0] reg_rdata, v, c, d;
    logic [12:0] bits;
    logic par, odd, p;
    int fails, n_compared, irqs, seed, len, k0;

    ast_core #(.TX_DEPTH(32)) dut(.mclk(mclk), .resetn(resetn),
        .cpu_req(cpu_req), .reg_rdata(reg_rdata), .rx_clk_pin(rx_clk),
        .rx_data_pin(rx_data), .tx_clk_pin(tx_clk),
        .tx_data_pin(tx_data_pin), .tx_irq(tx_irq));
    ast_remote remote(.rx_clk(rx_clk), .rx_data(rx_data), .tx_clk(tx_clk),
        .tx_data(tx_data_pin));

    // System clock, 20 ns period
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Interrupt pulses are one cycle wide, so count them at each edge
    always @(posedge mclk)
        if (tx_irq === 1'b1)
            irqs++;

    // Serial frame, start bit first, unused positions marking
    function automatic logic [12:0] frame(logic [7:0] dd, int n,
        logic pe, logic pb, logic stop);
        logic [12:0] f;
        f = '1;
        f[0] = 1'b0;
        for (int i = 0; i < n; i++)
            f[1 + i] = dd[i];
        if (pe)
            f[1 + n] = pb;
        f[1 + n + int'(pe)] = stop;
        return f;
    endfunction

    // Received byte: ones above the data, parity kept at position n
    function automatic logic [7:0] exp_rx(logic [7:0] dd, int n,
        logic pe, logic pb);
        logic [7:0] r;
        r = '1;
        for (int i = 0; i < n; i++)
            r[i] = dd[i];
        if (pe && n < 8)
            r[n] = pb;
        return r;
    endfunction

    task automatic chk(input string nm, input logic [12:0] e,
        input logic [12:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Register access: strobe for one cycle, then one idle cycle
    task automatic wr(input logic bk, input logic [7:0] a,
        input logic [7:0] w);
        @(negedge mclk) cpu_req = '{bk, a, 1'b1, 1'b0, w};
        @(negedge mclk) cpu_req.wr = 1'b0;
    endtask

    task automatic rd(input logic bk, input logic [7:0] a,
        output logic [7:0] r);
        @(negedge mclk) cpu_req = '{bk, a, 1'b0, 1'b1, 8'h00};
        @(negedge mclk) r = reg_rdata;
        cpu_req.rd = 1'b0;
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        #2000000;
        fails++;
        test_done;
    end

    initial
    begin
        seed = 65;
        fails = 0;
        n_compared = 0;
        irqs = 0;
        cpu_req = '0;
        resetn = 1'b0;
        repeat (10) @(posedge mclk);
        @(negedge mclk) resetn = 1'b1;
        rd(1'b0, RXCTL_ADDR, v);
        chk("rx_ctl_reset", 13'h00, v);
        rd(1'b0, TXIT_ADDR, v);
        chk("tx_timing_reset", 13'h06, v);
        rd(1'b0, 8'h00, v);
        chk("unmapped_read", 13'h00, v);
        // Baud pair is stored only and lives in bank 1
        wr(1'b1, BAUDH_ADDR, 8'h5c);
        wr(1'b1, BAUDL_ADDR, 8'ha3);
        rd(1'b1, BAUDH_ADDR, v);
        chk("baud_high", 13'h5c, v);
        rd(1'b1, BAUDL_ADDR, v);
        chk("baud_low", 13'ha3, v);
        rd(1'b0, BAUDH_ADDR, v);
        chk("baud_other_bank", 13'h00, v);
        $display("test reset done");
        // Transmit sweep over lengths, parity and interrupt timing
        wr(1'b0, IRQEN_ADDR, 8'h04);
        for (int i = 0; i < 8; i++)
        begin
            len = 5 + i % 4;
            par = (i % 3) != 0;
            odd = i[0];
            d = (i == 0) ? 8'hff : 8'($random(seed));
            p = ^(d & (8'hff >> (8 - len))) ^ odd;
            wr(1'b1, MODEA_ADDR, {4'h0, odd, par, 2'(len - 5)});
            wr(1'b0, TXIT_ADDR, {7'h0, i[1]});
            k0 = irqs;
            wr(1'b0, DATA_ADDR, d);
            rd(1'b0, TXIT_ADDR, v);
            chk("shift_empty_clear", 13'h0, v[TXI_SEMPTY]);
            chk("holding_empty", 13'h1, v[TXI_HEMPTY]);
            chk("irq_at_load", 13'(!i[1]), 13'(irqs - k0));
            remote.get(len + 2 + int'(par), 1, bits);
            chk("tx_frame", frame(d, len, par, p, 1'b1), bits);
            chk("irq_total", 13'h1, 13'(irqs - k0));
            chk("tx_idle", 13'h1, tx_data_pin);
            rd(1'b0, TXIT_ADDR, v);
            chk("shift_empty_set", 13'h1, v[TXI_SEMPTY]);
        end
        wr(1'b1, MODEB_ADDR, 8'h01);
        remote.tick(b);
        remote.tick(b);
        chk("break_low", 13'h0, tx_data_pin);
        wr(1'b1, MODEB_ADDR, 8'h00);
        remote.tick(b);
        remote.tick(b);
        chk("break_clear", 13'h1, tx_data_pin);
        // Divided rates 16/32/64, two stops, wake bit in the parity slot
        for (int j = 1; j < 4; j++)
        begin
            d = 8'($random(seed));
            wr(1'b1, MODEA_ADDR, {2'(j), 6'h33});
            wr(1'b1, MODEB_ADDR, {6'h00, j[0], 1'b0});
            wr(1'b0, DATA_ADDR, d);
            remote.get(12, 1 << (j + 3), bits);
            chk("tx_divided", frame(d, 8, 1'b1, j[0], 1'b1), bits);
        end
        $display("test transmit done");
        // Receiver ignores the line until enabled
        wr(1'b1, MODEA_ADDR, 8'h03);
        remote.send(frame(8'h41, 8, 1'b0, 1'b0, 1'b1), 10, 1);
        rd(1'b0, RXCTL_ADDR, v);
        chk("rx_disabled", 13'h0, v[RXC_FULL]);
        wr(1'b0, RXCTL_ADDR, 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            len = 5 + i % 4;
            par = i > 1;
            odd = i[0];
            d = 8'($random(seed));
            p = ^(d & (8'hff >> (8 - len))) ^ odd ^ (i == 4);
            wr(1'b1, MODEA_ADDR, {4'h0, odd, par, 2'(len - 5)});
            remote.send(frame(d, len, par, p, i != 5),
                len + 2 + int'(par), 1);
            rd(1'b0, RXCTL_ADDR, c);
            rd(1'b0, DATA_ADDR, v);
            chk("rx_parity_err", 13'(i == 4), c[RXC_PE]);
            chk("rx_frame_err", 13'(i == 5), c[RXC_FE]);
            if (i != 5)
            begin
                chk("rx_full", 13'h1, c[RXC_FULL]);
                chk("rx_data", exp_rx(d, len, par, p), v);
                d = d & (8'hff >> (8 - len));
                p = d < 8'h20 || d == 8'h7f;
                chk("rx_ctl_char", 13'(p), c[RXC_CTL]);
            end
            rd(1'b0, RXCTL_ADDR, c);
            chk("flags_sticky", 13'(i >= 4), c[RXC_PE] | c[RXC_FE]);
            wr(1'b0, RXCTL_ADDR, 8'h01);
        end
        // Two characters with no read between
        wr(1'b1, MODEA_ADDR, 8'h03);
        remote.send(frame(8'h5a, 8, 1'b0, 1'b0, 1'b1), 10, 1);
        remote.send(frame(8'hc3, 8, 1'b0, 1'b0, 1'b1), 10, 1);
        rd(1'b0, RXCTL_ADDR, c);
        rd(1'b0, DATA_ADDR, v);
        chk("rx_overrun", 13'h1, c[RXC_OVR]);
        chk("rx_newest", 13'hc3, v);
        // Divided receive with wake-up; wake bit sits in the parity slot
        wr(1'b0, RXCTL_ADDR, 8'h01);
        for (int j = 1; j < 4; j++)
        begin
            d = 8'($random(seed));
            wr(1'b1, MODEA_ADDR, {2'(j), 6'h23});
            remote.send(frame(d, 8, 1'b1, j[0], 1'b1), 11, 1 << (j + 3));
            rd(1'b0, RXCTL_ADDR, c);
            rd(1'b0, DATA_ADDR, v);
            chk("rx_wake_full", 13'(j[0]), c[RXC_FULL]);
            if (j[0])
                chk("rx_divided", d, v);
        end
        $display("test receive done");
        test_done;
    end
endmodule
